// File: hw/pcl_pkg.sv
// pcl_pkg: constants, register map and types for the pid control law block
`default_nettype none
package pcl_pkg;
  // arithmetic and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SAMPLE_MS = 100;
  localparam int MS_PER_S = 1000;
  localparam int SAMPLE_CYCLES_DEF = SAMPLE_MS * (CLK_HZ / MS_PER_S);
  localparam int PB_SCALE = 1000;
  localparam int CB_AUTO_MULT = 3;
  localparam int GAIN_SCALE = 10;
  localparam int INT_FRAC = 10;
  localparam int ESCORT_SHIFT = 3;
  localparam logic signed [15:0] FULL_DEMAND = 16'h03E8;
  localparam logic [15:0] AUTO_VALUE = 16'h0000;
  localparam logic [15:0] OFF_VALUE = 16'h0000;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT = 8'h04;
  localparam logic [7:0] ADDR_PBAND = 8'h08;
  localparam logic [7:0] ADDR_ITIME = 8'h0C;
  localparam logic [7:0] ADDR_DTIME = 8'h10;
  localparam logic [7:0] ADDR_CB_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CB_LOW = 8'h18;
  localparam logic [7:0] ADDR_COOL_GAIN = 8'h1C;
  localparam logic [7:0] ADDR_RANGE_LO = 8'h20;
  localparam logic [7:0] ADDR_RANGE_HI = 8'h24;
  localparam logic [7:0] ADDR_HEAT_OUT = 8'h28;
  localparam logic [7:0] ADDR_COOL_OUT = 8'h2C;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  // control register fields
  localparam int CTRL_HC_BIT = 0;
  localparam int CTRL_CT_LSB = 1;
  localparam int CTRL_CT_MSB = 2;
  // reset values
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;
  localparam logic [15:0] RST_PBAND = 16'h0064;
  localparam logic [15:0] RST_ITIME = 16'h0168;
  localparam logic [15:0] RST_DTIME = 16'h003C;
  localparam logic [15:0] RST_CB = 16'h0000;
  localparam logic [15:0] RST_COOL_GAIN = 16'h0028;
  localparam logic [15:0] RST_RANGE_LO = 16'h0000;
  localparam logic [15:0] RST_RANGE_HI = 16'h03E8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    COOL_LINEAR = 2'h0, COOL_WATER = 2'h1, COOL_OIL = 2'h2, COOL_FAN = 2'h3
  } pcl_cool_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_BAND = 4'h2, ST_TERMS = 4'h4, ST_SUM = 4'h8
  } pcl_state_t;
  typedef enum logic [3:0] {
    CB_NONE = 4'h1, CB_LOW = 4'h2, CB_HIGH = 4'h4, CB_ESCORT = 4'h8
  } pcl_cb_t;
endpackage
`default_nettype wire

// File: hw/pcl_cool_curve.sv
// pcl_cool_curve: maps linear cool demand onto the selected cooling characteristic
`timescale 1ns/10ps
`default_nettype none
module pcl_cool_curve
  import pcl_pkg::*;
(
  input wire logic [1:0] cooling_type_select_in,
  input wire logic [15:0] demand_in,
  output logic [15:0] mapped_out
);
  logic [47:0] x;
  logic [47:0] sq;
  logic [47:0] full;
  logic [47:0] res;
  always_comb begin
    x = 48'(demand_in);
    full = 48'(FULL_DEMAND);
    sq = (x * x) / full;
    res = x;
    case (pcl_cool_t'(cooling_type_select_in))
      COOL_LINEAR: res = x;
      // evaporative water cooling is fierce at high demand, so soften the low end
      COOL_WATER: res = sq;
      COOL_OIL: res = (x + sq) >> 1;
      COOL_FAN: res = (sq * x) / full;
      default: res = x;
    endcase
    mapped_out = res[15:0];
  end
endmodule // pcl_cool_curve
`default_nettype wire

// File: hw/pcl_control_law.sv
// pcl_control_law: pid heat/cool control law with cutback, axi4-lite registers
//
// Contract
// - linear output across band, heat or heat/cool
// - below band full on, above band off
// - band is tenths of a percent of input range
// - integral raises below setpoint, lowers above
// - integral time 1..9999 s, longer slower
// - integral off gives no integral action
// - derivative off gives no derivative action
// - derivative taken on measured value change
// - selectable linear, water, oil, fan cooling
// - cool band scaled by relative cool gain
// - saturated outside band: shift to cutback point
// - hold shifted band until value enters
// - falling value: mirror shift, other point
// - cutback independent of pid terms
// - auto cutback equals three proportional bands
// - demand is sum of three terms
`timescale 1ns/10ps
`default_nettype none
module pcl_control_law
  import pcl_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic signed [15:0] measured_value_in,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [15:0] heat_demand_out,
  output logic [15:0] cool_demand_out,
  output logic update_out
);
  localparam int W = 64;
  typedef logic signed [W-1:0] pcl_wide_t;
  // bus and register state
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [15:0] ctrl_ff, nxt_ctrl, setpoint_ff, nxt_setpoint;
  logic [15:0] proportional_band_width_ff, nxt_proportional_band_width;
  logic [15:0] itime_ff, nxt_itime, derivative_time_setting_ff, nxt_derivative_time_setting;
  logic [15:0] cutback_high_point_ff, nxt_cutback_high_point;
  logic [15:0] cutback_low_point_ff, nxt_cutback_low_point;
  logic [15:0] cool_gain_ff, nxt_cool_gain, range_lo_ff, nxt_range_lo;
  logic [15:0] range_hi_ff, nxt_range_hi;
  // compute state
  pcl_state_t state_ff, nxt_state;
  pcl_cb_t cb_ff, nxt_cb;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick, update_ff, nxt_update, sat_hi_ff, nxt_sat_hi;
  logic sat_lo_ff, nxt_sat_lo;
  pcl_wide_t shift_ff, nxt_shift, p_ff, nxt_p, acc_ff, nxt_acc, d_ff, nxt_d;
  logic signed [15:0] pv_prev_ff, nxt_pv_prev;
  logic [15:0] heat_ff, nxt_heat, cool_ff, nxt_cool, cool_lin_ff, nxt_cool_lin;
  logic [15:0] cool_mapped;
  pcl_wide_t pv_w, sp_w, pb_span, cb_hi_eff, cb_lo_eff, err, sum, full_w;
  logic heat_cool;

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic pcl_wide_t clampw(input pcl_wide_t v, input pcl_wide_t lo,
                                       input pcl_wide_t hi);
    clampw = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // configuration-derived values, shared by the compute steps
  always_comb begin
    heat_cool = ctrl_ff[CTRL_HC_BIT];
    full_w = W'(FULL_DEMAND);
    pv_w = W'(measured_value_in);
    sp_w = W'($signed(setpoint_ff));
    pb_span = ((W'($signed(range_hi_ff)) - W'($signed(range_lo_ff)))
               * $signed(W'(proportional_band_width_ff))) / W'(PB_SCALE);
    // a zero span would divide by zero; treat it as the narrowest band
    if (pb_span < W'(1)) pb_span = W'(1);
    cb_hi_eff = (cutback_high_point_ff == AUTO_VALUE) ? pb_span * W'(CB_AUTO_MULT)
                : W'(cutback_high_point_ff);
    cb_lo_eff = (cutback_low_point_ff == AUTO_VALUE) ? pb_span * W'(CB_AUTO_MULT)
                : W'(cutback_low_point_ff);
    err = sp_w + shift_ff - pv_w;
    sum = clampw(p_ff + (acc_ff >>> INT_FRAC) + d_ff,
                 heat_cool ? -full_w : W'(0), full_w);
  end

  // axi4-lite slave and register file
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_setpoint = setpoint_ff;
    nxt_proportional_band_width = proportional_band_width_ff;
    nxt_itime = itime_ff;
    nxt_derivative_time_setting = derivative_time_setting_ff;
    nxt_cutback_high_point = cutback_high_point_ff;
    nxt_cutback_low_point = cutback_low_point_ff;
    nxt_cool_gain = cool_gain_ff;
    nxt_range_lo = range_lo_ff;
    nxt_range_hi = range_hi_ff;
    if (axi_awvalid_in && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = axi_awaddr_in;
    end
    if (axi_wvalid_in && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = axi_wdata_in;
      nxt_w_strb = axi_wstrb_in;
    end
    if (bvalid_ff && axi_bready_in) nxt_bvalid = 1'b0;
    if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (aw_addr_ff)
        ADDR_CTRL: nxt_ctrl = wmerge(ctrl_ff, w_data_ff, w_strb_ff);
        ADDR_SETPOINT: nxt_setpoint = wmerge(setpoint_ff, w_data_ff, w_strb_ff);
        ADDR_PBAND: nxt_proportional_band_width =
          wmerge(proportional_band_width_ff, w_data_ff, w_strb_ff);
        ADDR_ITIME: nxt_itime = wmerge(itime_ff, w_data_ff, w_strb_ff);
        ADDR_DTIME: nxt_derivative_time_setting =
          wmerge(derivative_time_setting_ff, w_data_ff, w_strb_ff);
        ADDR_CB_HIGH: nxt_cutback_high_point = wmerge(cutback_high_point_ff, w_data_ff, w_strb_ff);
        ADDR_CB_LOW: nxt_cutback_low_point = wmerge(cutback_low_point_ff, w_data_ff, w_strb_ff);
        ADDR_COOL_GAIN: nxt_cool_gain = wmerge(cool_gain_ff, w_data_ff, w_strb_ff);
        ADDR_RANGE_LO: nxt_range_lo = wmerge(range_lo_ff, w_data_ff, w_strb_ff);
        ADDR_RANGE_HI: nxt_range_hi = wmerge(range_hi_ff, w_data_ff, w_strb_ff);
        // read-only words ignore writes but still answer okay
        ADDR_HEAT_OUT, ADDR_COOL_OUT, ADDR_STATUS: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_aw_hold;
    nxt_wready = !nxt_w_hold;
    if (rvalid_ff && axi_rready_in) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
    if (axi_arvalid_in && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (axi_araddr_in)
        ADDR_CTRL: nxt_rdata[15:0] = ctrl_ff;
        ADDR_SETPOINT: nxt_rdata[15:0] = setpoint_ff;
        ADDR_PBAND: nxt_rdata[15:0] = proportional_band_width_ff;
        ADDR_ITIME: nxt_rdata[15:0] = itime_ff;
        ADDR_DTIME: nxt_rdata[15:0] = derivative_time_setting_ff;
        ADDR_CB_HIGH: nxt_rdata[15:0] = cutback_high_point_ff;
        ADDR_CB_LOW: nxt_rdata[15:0] = cutback_low_point_ff;
        ADDR_COOL_GAIN: nxt_rdata[15:0] = cool_gain_ff;
        ADDR_RANGE_LO: nxt_rdata[15:0] = range_lo_ff;
        ADDR_RANGE_HI: nxt_rdata[15:0] = range_hi_ff;
        ADDR_HEAT_OUT: nxt_rdata[15:0] = heat_ff;
        ADDR_COOL_OUT: nxt_rdata[15:0] = cool_ff;
        ADDR_STATUS: nxt_rdata[5:0] = {sat_lo_ff, sat_hi_ff, cb_ff};
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= RST_CTRL;
      setpoint_ff <= RST_SETPOINT;
      proportional_band_width_ff <= RST_PBAND;
      itime_ff <= RST_ITIME;
      derivative_time_setting_ff <= RST_DTIME;
      cutback_high_point_ff <= RST_CB;
      cutback_low_point_ff <= RST_CB;
      cool_gain_ff <= RST_COOL_GAIN;
      range_lo_ff <= RST_RANGE_LO;
      range_hi_ff <= RST_RANGE_HI;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      setpoint_ff <= nxt_setpoint;
      proportional_band_width_ff <= nxt_proportional_band_width;
      itime_ff <= nxt_itime;
      derivative_time_setting_ff <= nxt_derivative_time_setting;
      cutback_high_point_ff <= nxt_cutback_high_point;
      cutback_low_point_ff <= nxt_cutback_low_point;
      cool_gain_ff <= nxt_cool_gain;
      range_lo_ff <= nxt_range_lo;
      range_hi_ff <= nxt_range_hi;
    end
  end

  // sample tick divider and the per-tick compute sequence
  always_comb begin
    nxt_tick_cnt = tick_cnt_ff + 32'h0000_0001;
    nxt_tick = 1'b0;
    if (tick_cnt_ff == 32'(SAMPLE_CYCLES - 1)) begin
      nxt_tick_cnt = 32'h0000_0000;
      nxt_tick = 1'b1;
    end
    nxt_state = state_ff;
    nxt_cb = cb_ff;
    nxt_shift = shift_ff;
    nxt_p = p_ff;
    nxt_acc = acc_ff;
    nxt_d = d_ff;
    nxt_pv_prev = pv_prev_ff;
    nxt_heat = heat_ff;
    nxt_cool_lin = cool_lin_ff;
    nxt_cool = cool_ff;
    nxt_sat_hi = sat_hi_ff;
    nxt_sat_lo = sat_lo_ff;
    nxt_update = 1'b0;
    case (state_ff)
      ST_IDLE: if (tick_ff) nxt_state = ST_BAND;
      ST_BAND: begin
        nxt_state = ST_TERMS;
        case (cb_ff)
          CB_NONE: begin
            if (pv_w < sp_w - cb_lo_eff && sat_hi_ff) begin
              nxt_cb = CB_LOW;
              nxt_shift = pb_span - cb_lo_eff;
            end else if (pv_w > sp_w + cb_hi_eff && sat_lo_ff) begin
              nxt_cb = CB_HIGH;
              nxt_shift = cb_hi_eff - pb_span;
            end
          end
          CB_LOW: if (pv_w >= sp_w + shift_ff - pb_span) nxt_cb = CB_ESCORT;
          CB_HIGH: if (pv_w <= sp_w + shift_ff + pb_span) nxt_cb = CB_ESCORT;
          CB_ESCORT: begin
            // band slides back gradually so the value is led to setpoint, not dropped
            nxt_shift = shift_ff - (shift_ff >>> ESCORT_SHIFT);
            if ((shift_ff >>> ESCORT_SHIFT) == W'(0)) begin
              nxt_shift = W'(0);
              nxt_cb = CB_NONE;
            end
          end
          default: begin
            nxt_cb = CB_NONE;
            nxt_shift = W'(0);
          end
        endcase
      end
      ST_TERMS: begin
        nxt_state = ST_SUM;
        nxt_p = clampw((err * full_w) / pb_span, -full_w, full_w);
        if (itime_ff == OFF_VALUE) nxt_acc = W'(0);
        else if (cb_ff != CB_LOW && cb_ff != CB_HIGH)
          nxt_acc = clampw(acc_ff + ((nxt_p <<< INT_FRAC) * W'(SAMPLE_MS))
                           / ($signed(W'(itime_ff)) * W'(MS_PER_S)),
                           -(full_w <<< INT_FRAC), full_w <<< INT_FRAC);
        if (derivative_time_setting_ff == OFF_VALUE) nxt_d = W'(0);
        // settings are unsigned; keep the whole term signed so a rising value divides right
        else nxt_d = clampw(-(full_w * $signed(W'(derivative_time_setting_ff)) * W'(MS_PER_S)
                              * (pv_w - W'(pv_prev_ff))) / (pb_span * W'(SAMPLE_MS)),
                            -full_w, full_w);
        nxt_pv_prev = measured_value_in;
      end
      ST_SUM: begin
        nxt_state = ST_IDLE;
        nxt_update = 1'b1;
        nxt_heat = (sum > W'(0)) ? sum[15:0] : 16'h0000;
        nxt_cool_lin = (heat_cool && sum < W'(0))
          ? 16'(clampw((-sum * W'(cool_gain_ff)) / W'(GAIN_SCALE), W'(0), full_w))
          : 16'h0000;
        nxt_sat_hi = (sum == full_w);
        nxt_sat_lo = (sum == (heat_cool ? -full_w : W'(0)));
      end
      default: nxt_state = ST_IDLE;
    endcase
    // curve output lags the linear value by one cycle; settles the cycle after update_out
    nxt_cool = cool_mapped;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
      state_ff <= ST_IDLE;
      cb_ff <= CB_NONE;
      shift_ff <= '0;
      p_ff <= '0;
      acc_ff <= '0;
      d_ff <= '0;
      pv_prev_ff <= 16'h0000;
      heat_ff <= 16'h0000;
      cool_lin_ff <= 16'h0000;
      cool_ff <= 16'h0000;
      sat_hi_ff <= 1'b0;
      sat_lo_ff <= 1'b0;
      update_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
      state_ff <= nxt_state;
      cb_ff <= nxt_cb;
      shift_ff <= nxt_shift;
      p_ff <= nxt_p;
      acc_ff <= nxt_acc;
      d_ff <= nxt_d;
      pv_prev_ff <= nxt_pv_prev;
      heat_ff <= nxt_heat;
      cool_lin_ff <= nxt_cool_lin;
      cool_ff <= nxt_cool;
      sat_hi_ff <= nxt_sat_hi;
      sat_lo_ff <= nxt_sat_lo;
      update_ff <= nxt_update;
    end
  end

  pcl_cool_curve u_cool_curve (
    .cooling_type_select_in(ctrl_ff[CTRL_CT_MSB:CTRL_CT_LSB]),
    .demand_in(cool_lin_ff),
    .mapped_out(cool_mapped)
  );

  assign axi_awready_out = awready_ff;
  assign axi_wready_out = wready_ff;
  assign axi_bvalid_out = bvalid_ff;
  assign axi_bresp_out = bresp_ff;
  assign axi_arready_out = arready_ff;
  assign axi_rvalid_out = rvalid_ff;
  assign axi_rresp_out = rresp_ff;
  assign axi_rdata_out = rdata_ff;
  assign heat_demand_out = heat_ff;
  assign cool_demand_out = cool_ff;
  assign update_out = update_ff;

  default clocking cb_clk @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_tick_walk;
    tick_ff ##1 state_ff == ST_BAND ##1 state_ff == ST_TERMS ##1 state_ff == ST_SUM;
  endsequence
  a_tick_to_update: assert property (state_ff == ST_IDLE && tick_ff
    |-> s_tick_walk ##1 update_ff)
    else $error("update did not follow tick by four cycles");
  a_ti_off_clear: assert property (state_ff == ST_TERMS && itime_ff == OFF_VALUE
    |=> acc_ff == '0)
    else $error("integral kept with integral time off");
  a_td_off_zero: assert property (state_ff == ST_TERMS && derivative_time_setting_ff == OFF_VALUE
    |=> d_ff == '0)
    else $error("derivative applied with derivative time off");
  a_pv_flat_no_kick: assert property (state_ff == ST_TERMS && pv_w == W'(pv_prev_ff)
    |=> d_ff == '0)
    else $error("derivative without measured value change");
  a_heat_only_span: assert property (!heat_cool && update_ff |-> cool_demand_out == 16'h0000
    && $signed(heat_demand_out) <= FULL_DEMAND)
    else $error("heat only output outside span");
  a_below_band_full: assert property (state_ff == ST_TERMS && err >= pb_span
    && (acc_ff >>> INT_FRAC) >= W'(0) && itime_ff != OFF_VALUE
    && derivative_time_setting_ff == OFF_VALUE |-> ##2 heat_ff == FULL_DEMAND)
    else $error("below band not full on");
  a_integ_rises: assert property (state_ff == ST_TERMS && err > W'(0) && itime_ff != OFF_VALUE
    && cb_ff == CB_NONE |=> acc_ff >= $past(acc_ff))
    else $error("integral fell while below setpoint");
  a_cb_hold_band: assert property (state_ff == ST_BAND && cb_ff == CB_LOW
    && pv_w < sp_w + shift_ff - pb_span |=> cb_ff == CB_LOW && $stable(shift_ff))
    else $error("cutback band moved before entry");
  a_cb_auto_three: assert property (cutback_low_point_ff == AUTO_VALUE
    |-> cb_lo_eff == pb_span * W'(CB_AUTO_MULT))
    else $error("auto cutback not three bands");
  a_write_answer: assert property (axi_awvalid_in && awready_ff && axi_wvalid_in && wready_ff
    && !bvalid_ff |-> ##2 bvalid_ff)
    else $error("write response late");
endmodule // pcl_control_law
`default_nettype wire

// File: tb/pcl_sensor_model.sv
// pcl_sensor_model: measurement stage that feeds the measured value
`timescale 1ns/10ps
`default_nettype none
module pcl_sensor_model (
  input wire logic clk_in,
  input wire logic signed [15:0] target_in,
  output logic signed [15:0] measured_value_out
);
  // one conversion per clock, so the value lags the command by a cycle
  always_ff @(posedge clk_in) begin
    measured_value_out <= target_in;
  end
endmodule // pcl_sensor_model
`default_nettype wire

// File: tb/pid_control_law_tb_top.sv
// pid_control_law_tb_top: self-checking bench for the control law block
`timescale 1ns/10ps
`default_nettype none
module pid_control_law_tb_top;
  import pcl_pkg::*;
  typedef struct {logic [15:0] ctrl, gain, pv, heat, cool;} pcl_row_t;
  logic clk_in, rst_in, awv, wv, bready, arv, rready;
  logic awready, wready, bvalid, arready, rvalid, upd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] heat, cool;
  logic signed [15:0] pv, pv_cmd;
  int n_errors, n_checks, cyc;
  logic [15:0] rst_v [10] = '{RST_CTRL, RST_SETPOINT, RST_PBAND, RST_ITIME, RST_DTIME,
    RST_CB, RST_CB, RST_COOL_GAIN, RST_RANGE_LO, RST_RANGE_HI};
  // setpoint 500, band span 100: heat-only rows then heat/cool rows
  pcl_row_t rows [12] = '{
    '{16'h0000, 16'h0028, 16'h01F4, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0028, 16'h01C2, 16'h01F4, 16'h0000},
    '{16'h0000, 16'h0028, 16'h01DB, 16'h00FA, 16'h0000},
    '{16'h0000, 16'h0028, 16'h0190, 16'h03E8, 16'h0000},
    '{16'h0000, 16'h0028, 16'h012C, 16'h03E8, 16'h0000},
    '{16'h0000, 16'h0028, 16'h0226, 16'h0000, 16'h0000},
    '{16'h0001, 16'h0028, 16'h01FE, 16'h0000, 16'h0190},
    '{16'h0003, 16'h0028, 16'h01FE, 16'h0000, 16'h00A0},
    '{16'h0005, 16'h0028, 16'h01FE, 16'h0000, 16'h0118},
    '{16'h0007, 16'h0028, 16'h01FE, 16'h0000, 16'h0040},
    '{16'h0001, 16'h0014, 16'h01FE, 16'h0000, 16'h00C8},
    '{16'h0001, 16'h0028, 16'h01EA, 16'h0064, 16'h0000}};
  pcl_control_law #(.SAMPLE_CYCLES(20)) i_pcl_control_law (.clk_in(clk_in), .rst_in(rst_in),
    .measured_value_in(pv), .axi_awaddr_in(awaddr), .axi_awvalid_in(awv),
    .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(4'h3),
    .axi_wvalid_in(wv), .axi_wready_out(wready), .axi_bresp_out(bresp),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
    .axi_arvalid_in(arv), .axi_arready_out(arready), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .axi_rvalid_out(rvalid), .axi_rready_in(rready),
    .heat_demand_out(heat), .cool_demand_out(cool), .update_out(upd));
  pcl_sensor_model i_pcl_sensor_model (.clk_in(clk_in), .target_in(pv_cmd),
    .measured_value_out(pv));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // every bus task starts after an edge and ends on the edge that took the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // two extra edges let the cool output settle after the update pulse
  task automatic upd_wait(input int n);
    repeat (n) do @(posedge clk_in); while (upd !== 1'b1);
    repeat (2) @(posedge clk_in);
  endtask
  task automatic restart;
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk({upd, heat, cool[14:0]}, 32'h0000_0000);
    rst_in <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd_reg(8'(i * 4));
      chk(rd, {16'h0000, rst_v[i]});
    end
  endtask
  initial begin
    {rst_in, awv, wv, bready, arv, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    // value starts at the reset setpoint so no cutback is entered before setup
    pv_cmd = 16'h0000;
    restart();
    wr(8'h40, 32'h0000_0001);
    chk(rs, RESP_SLVERR);
    rd_reg(8'h40);
    chk(rs, RESP_SLVERR);
    wr(ADDR_HEAT_OUT, 32'h0000_FFFF);
    chk(rs, RESP_OKAY);
    wr(ADDR_SETPOINT, 32'h0000_01F4);
    wr(ADDR_ITIME, 32'h0000_0000);
    wr(ADDR_DTIME, 32'h0000_0000);
    wr(ADDR_CB_HIGH, 32'h0000_7FFF);
    wr(ADDR_CB_LOW, 32'h0000_7FFF);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {16'h0000, rows[i].ctrl});
      wr(ADDR_COOL_GAIN, {16'h0000, rows[i].gain});
      pv_cmd <= rows[i].pv;
      upd_wait(2);
      chk(heat, rows[i].heat);
      chk(cool, rows[i].cool);
    end
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_RANGE_HI, 32'h0000_07D0);
    pv_cmd <= 16'h01C2;
    upd_wait(2);
    chk(heat, 16'h00FA);
    wr(ADDR_RANGE_HI, 32'h0000_03E8);
    wr(ADDR_DTIME, 32'h0000_000A);
    pv_cmd <= 16'h01E0;
    upd_wait(3);
    wr(ADDR_SETPOINT, 32'h0000_01FE);
    upd_wait(1);
    chk(heat, 16'h012C);
    pv_cmd <= 16'h01D6;
    upd_wait(1);
    chk(heat, 16'h03E8);
    upd_wait(1);
    chk(heat, 16'h0190);
    wr(ADDR_DTIME, 32'h0000_0000);
    pv_cmd <= 16'h01CC;
    upd_wait(1);
    chk(heat, 16'h01F4);
    wr(ADDR_ITIME, 32'h0000_0001);
    upd_wait(2);
    chk(32'(heat > 16'h01F4), 32'h0000_0001);
    wr(ADDR_ITIME, 32'h0000_0000);
    upd_wait(2);
    chk(heat, 16'h01F4);
    // auto cutback low sits 300 below the setpoint of 510
    wr(ADDR_ITIME, 32'h0000_0001);
    wr(ADDR_CB_LOW, 32'h0000_0000);
    pv_cmd <= 16'h00FA;
    upd_wait(2);
    chk(heat, 16'h03E8);
    rd_reg(ADDR_STATUS);
    chk(rd[3:0], 4'h1);
    pv_cmd <= 16'h0096;
    upd_wait(2);
    rd_reg(ADDR_STATUS);
    chk(rd[5:0], 6'h12);
    pv_cmd <= 16'h0104;
    upd_wait(2);
    rd_reg(ADDR_STATUS);
    chk(rd[3:0], 4'h8);
    restart();
    pv_cmd <= 16'h01F4;
    upd_wait(3);
    rd_reg(ADDR_STATUS);
    chk(rd[5:0], 6'h24);
    wrap_up();
  end
endmodule // pid_control_law_tb_top
`default_nettype wire
